// ---- verilog/bgdbg_params.svh ----
/*
 Constants of the debug-entry control: opcodes, line nibbles, vector numbers, synchroniser stages.
 Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef BGDBG_PARAMS_SVH
`define BGDBG_PARAMS_SVH

`define BGDBG_OP_ENTER_DEBUG   16'h4afa
`define BGDBG_OP_BREAKPOINT_REQUEST_N_FIRST    16'h4848
`define BGDBG_OP_BREAKPOINT_REQUEST_N_LAST     16'h484f
`define BGDBG_LINE_A           4'ha
`define BGDBG_LINE_F           4'hf
`define BGDBG_VEC_ILLEGAL      8'h04
`define BGDBG_VEC_TRACE        8'h09
`define BGDBG_VEC_LINE_A       8'h0a
`define BGDBG_VEC_LINE_F       8'h0b
`define BGDBG_VEC_BREAKPOINT   8'h0c
`define BGDBG_SYNC_STAGES      2

`endif

// ---- verilog/bgdbg_pkg.sv ----
/*
 Types of the debug-entry control.
 Assumes bgdbg_params.svh is on the include path.
*/
`include "bgdbg_params.svh"

package bgdbg_pkg;

	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_BREAKPOINT,
		SRC_OPCODE,
		SRC_DOUBLE_FAULT
	} bgdbg_src_t;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_DEBUG,
		ST_HALTED
	} bgdbg_state_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] opcode;
		logic        change_of_flow;
	} bgdbg_instr_t;

	typedef struct packed {
		logic       take;
		logic [7:0] vector;
	} bgdbg_exc_t;

endpackage : bgdbg_pkg

// ---- verilog/bgdbg_sync.sv ----
/*
 Two-flop synchroniser of one level, free running so it fills during reset.
 Assumes the input may change at any time relative to sys_clk.
*/
`timescale 1ns/1ps

module bgdbg_sync (
	// Clock
	input  wire logic sys_clk,
	// Level
	input  wire logic async_in,
	output logic      sync_out
);

	typedef struct packed {
		logic meta;
		logic stable;
	} bgdbg_sync_st_t;

	bgdbg_sync_st_t st_reg;
	bgdbg_sync_st_t st_next;

	always_comb begin
		st_next.meta   = async_in;
		st_next.stable = st_reg.meta;
	end

	always_ff @(posedge sys_clk) begin
		st_reg <= st_next;
	end

	assign sync_out = st_reg.stable;

endmodule : bgdbg_sync

// ---- verilog/bgdbg_entry.sv ----
/*
 Debug-entry control: arms background debug mode at reset release, then steers each
 debug source into background debug mode or into a normal exception or halt.
 Assumes the core presents bus-cycle ends, faults and executed opcodes as one-cycle pulses.
*/
// Operation
// - Low breakpoint request at reset release arms background debug mode.
// - Armed state holds until the next reset, whatever the request does.
// - High request at reset release leaves debug mode disarmed.
// - Every reset release captures the request level afresh.
// - Armed: breakpoint, enter opcode, double fault or peripheral request enter debug.
// - Disarmed: every debug source but double fault is handled as a normal exception.
// - Armed: an acknowledged breakpoint request enters debug mode.
// - Disarmed: acknowledged breakpoint raises exception vector 0C.
// - No breakpoint acknowledge bus cycle on debug entry.
// - Opcode 4AFA enters debug mode when armed.
// - Opcode 4AFA takes the illegal instruction trap when disarmed.
// - Two successive bus faults halt if disarmed, enter debug if armed.
// - Opcodes 4848 to 484F never enter debug; substitution or illegal.
// - Peripheral requests share the request line, handled as external ones.
// - Trace raises trace exception after each or flow-changing instruction, but not after A-line, F-line, 4848 to 484F or 4AFA opcodes.
// - A-line and F-line opcodes use their own emulation vectors.
// - Debug entry suspends execution and asserts the frozen output.
`timescale 1ns/1ps
`include "bgdbg_params.svh"

module bgdbg_entry (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  nrst,
	// Breakpoint request from tool or peripherals
	input  wire logic                  breakpoint_request_n,
	input  wire logic                  periph_breakpoint_n,
	// Core events
	input  wire logic                  bus_cycle_end,
	input  wire logic                  bus_fault,
	input  wire logic                  bus_cycle_ok,
	input  wire bgdbg_pkg::bgdbg_instr_t instr,
	input  wire logic                  breakpoint_request_n_substitute,
	input  wire logic                  debug_resume,
	// Trace control
	input  wire logic                  trace_enable,
	input  wire logic                  trace_flow_only,
	// Status and results
	output logic                       background_debug_mode_en,
	output logic                       frozen,
	output logic                       exec_suspend,
	output logic                       halted,
	output bgdbg_pkg::bgdbg_src_t      entry_source,
	output bgdbg_pkg::bgdbg_exc_t      exception,
	output logic                       breakpoint_request_n_ack_cycle,
	output logic                       breakpoint_request_n_substitute_go
);

	typedef struct packed {
		logic                   in_reset;
		logic                   armed;
		bgdbg_pkg::bgdbg_state_t state;
		logic                   fault_seen;
		bgdbg_pkg::bgdbg_src_t  source;
		bgdbg_pkg::bgdbg_exc_t  exc;
		logic                   ack_cycle;
		logic                   subst;
		logic                   frozen;
		logic                   suspend;
		logic                   halted;
	} bgdbg_st_t;

	bgdbg_st_t st_reg;
	bgdbg_st_t st_next;
	logic      req_sync_n;

	function automatic logic is_breakpoint_request_n_op(input logic [15:0] op);
		is_breakpoint_request_n_op = (op >= `BGDBG_OP_BREAKPOINT_REQUEST_N_FIRST) && (op <= `BGDBG_OP_BREAKPOINT_REQUEST_N_LAST);
	endfunction : is_breakpoint_request_n_op

	// Request line shared by external and peripheral sources
	bgdbg_sync u_req_sync (
		.sys_clk  (sys_clk),
		.async_in (breakpoint_request_n & periph_breakpoint_n),
		.sync_out (req_sync_n)
	);

	logic bp_ack;
	logic enter_op;
	logic double_fault;
	logic running;

	always_comb begin
		st_next = st_reg;
		running = (st_reg.state == bgdbg_pkg::ST_RUN);
		bp_ack = running && bus_cycle_end && !req_sync_n;
		enter_op = running && instr.valid && (instr.opcode == `BGDBG_OP_ENTER_DEBUG);
		double_fault = running && bus_fault && st_reg.fault_seen;
		st_next.exc = '0;
		st_next.ack_cycle = 1'b0;
		st_next.subst = 1'b0;
		st_next.in_reset = 1'b0;
		// Capture on the first clock after reset release
		if (st_reg.in_reset) begin
			st_next.armed = !req_sync_n;
		end
		if (running) begin
			if (bus_fault) begin
				st_next.fault_seen = 1'b1;
			end else if (bus_cycle_ok) begin
				st_next.fault_seen = 1'b0;
			end
		end
		if (double_fault) begin
			st_next.source = bgdbg_pkg::SRC_DOUBLE_FAULT;
			st_next.state = st_reg.armed ? bgdbg_pkg::ST_DEBUG : bgdbg_pkg::ST_HALTED;
		end else if (bp_ack) begin
			if (st_reg.armed) begin
				st_next.state = bgdbg_pkg::ST_DEBUG;
				st_next.source = bgdbg_pkg::SRC_BREAKPOINT;
			end else begin
				st_next.exc.take = 1'b1;
				st_next.exc.vector = `BGDBG_VEC_BREAKPOINT;
				st_next.ack_cycle = 1'b1;
			end
		end else if (enter_op) begin
			if (st_reg.armed) begin
				st_next.state = bgdbg_pkg::ST_DEBUG;
				st_next.source = bgdbg_pkg::SRC_OPCODE;
			end else begin
				st_next.exc.take = 1'b1;
				st_next.exc.vector = `BGDBG_VEC_ILLEGAL;
			end
		end else if (running && instr.valid) begin
			if (is_breakpoint_request_n_op(instr.opcode)) begin
				if (breakpoint_request_n_substitute) begin
					st_next.subst = 1'b1;
				end else begin
					st_next.exc.take = 1'b1;
					st_next.exc.vector = `BGDBG_VEC_ILLEGAL;
				end
			end else if (instr.opcode[15:12] == `BGDBG_LINE_A) begin
				st_next.exc.take = 1'b1;
				st_next.exc.vector = `BGDBG_VEC_LINE_A;
			end else if (instr.opcode[15:12] == `BGDBG_LINE_F) begin
				st_next.exc.take = 1'b1;
				st_next.exc.vector = `BGDBG_VEC_LINE_F;
			end else if (trace_enable && (!trace_flow_only || instr.change_of_flow)) begin
				st_next.exc.take = 1'b1;
				st_next.exc.vector = `BGDBG_VEC_TRACE;
			end
		end
		if (st_reg.state == bgdbg_pkg::ST_DEBUG && debug_resume) begin
			st_next.state = bgdbg_pkg::ST_RUN;
			st_next.fault_seen = 1'b0;
		end
		if (!nrst) begin
			st_next = '0;
			st_next.in_reset = 1'b1;
			st_next.state = bgdbg_pkg::ST_RUN;
			st_next.source = bgdbg_pkg::SRC_NONE;
		end
		st_next.frozen = (st_next.state == bgdbg_pkg::ST_DEBUG);
		st_next.suspend = (st_next.state != bgdbg_pkg::ST_RUN);
		st_next.halted = (st_next.state == bgdbg_pkg::ST_HALTED);
	end

	always_ff @(posedge sys_clk) begin
		st_reg <= st_next;
	end

	assign background_debug_mode_en = st_reg.armed;
	assign frozen = st_reg.frozen;
	assign exec_suspend = st_reg.suspend;
	assign halted = st_reg.halted;
	assign entry_source = st_reg.source;
	assign exception = st_reg.exc;
	assign breakpoint_request_n_ack_cycle = st_reg.ack_cycle;
	assign breakpoint_request_n_substitute_go = st_reg.subst;

	// Checks
	AST_ARM_LOW: assert property (@(posedge sys_clk) disable iff (!nrst)
		st_reg.in_reset && !req_sync_n |=> background_debug_mode_en)
		else $error("Debug mode not armed after low request at release");
	AST_DISARM_HIGH: assert property (@(posedge sys_clk) disable iff (!nrst)
		st_reg.in_reset && req_sync_n |=> !background_debug_mode_en)
		else $error("Debug mode armed after high request at release");
	AST_ARM_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
		!st_reg.in_reset |=> background_debug_mode_en == $past(background_debug_mode_en))
		else $error("Debug arm state changed outside reset");
	AST_BP_ENTER: assert property (@(posedge sys_clk) disable iff (!nrst)
		bp_ack && !double_fault && background_debug_mode_en |=> frozen && !breakpoint_request_n_ack_cycle)
		else $error("Armed breakpoint did not enter debug cleanly");
	AST_BP_VECTOR: assert property (@(posedge sys_clk) disable iff (!nrst)
		bp_ack && !double_fault && !background_debug_mode_en
		|=> exception.take && exception.vector == 8'h0c && !frozen)
		else $error("Disarmed breakpoint missed vector 0C");
	AST_OP_ILLEGAL: assert property (@(posedge sys_clk) disable iff (!nrst)
		enter_op && !bp_ack && !double_fault && !background_debug_mode_en
		|=> exception.take && exception.vector == 8'h04)
		else $error("Disarmed enter opcode did not trap");
	AST_DFAULT: assert property (@(posedge sys_clk) disable iff (!nrst)
		double_fault |=> (frozen == background_debug_mode_en) && (halted == !frozen))
		else $error("Double fault outcome wrong");
	AST_BREAKPOINT_REQUEST_N_OP: assert property (@(posedge sys_clk) disable iff (!nrst)
		running && instr.valid && is_breakpoint_request_n_op(instr.opcode) && !bp_ack && !bus_fault
		|=> !frozen)
		else $error("Breakpoint opcode entered debug mode");
	AST_TRACE: assert property (@(posedge sys_clk) disable iff (!nrst)
		running && instr.valid && trace_enable && !trace_flow_only && !bp_ack
		&& !bus_fault && instr.opcode[15:12] != 4'ha && instr.opcode[15:12] != 4'hf
		&& !is_breakpoint_request_n_op(instr.opcode) && instr.opcode != 16'h4afa
		|=> exception.take && exception.vector == 8'h09)
		else $error("Trace exception missing");

	AST_ARM_AFRESH: assert property (@(posedge sys_clk) disable iff (!nrst)
		st_reg.in_reset
		|=> background_debug_mode_en == !$past(req_sync_n))
		else $error("Arm state not captured at reset release");

	AST_SYNC_DELAY: assert property (@(posedge sys_clk) disable iff (!nrst)
		1'b1
		|-> req_sync_n == $past(breakpoint_request_n & periph_breakpoint_n, 2))
		else $error("Request synchroniser delay wrong");

	AST_BP_SOURCE: assert property (@(posedge sys_clk) disable iff (!nrst)
		bp_ack && !double_fault && background_debug_mode_en
		|=> entry_source == bgdbg_pkg::SRC_BREAKPOINT)
		else $error("Breakpoint entry source wrong");

	AST_BP_NO_EXC: assert property (@(posedge sys_clk) disable iff (!nrst)
		bp_ack && !double_fault && background_debug_mode_en
		|=> !exception.take)
		else $error("Armed breakpoint raised an exception");

	AST_ACK_DISARMED: assert property (@(posedge sys_clk) disable iff (!nrst)
		breakpoint_request_n_ack_cycle
		|-> !background_debug_mode_en && exception.vector == `BGDBG_VEC_BREAKPOINT)
		else $error("Acknowledge cycle without disarmed breakpoint");

	AST_NO_ACK_FROZEN: assert property (@(posedge sys_clk) disable iff (!nrst)
		frozen
		|-> !breakpoint_request_n_ack_cycle)
		else $error("Acknowledge cycle while in debug mode");

	AST_DISARM_NO_FREEZE: assert property (@(posedge sys_clk) disable iff (!nrst)
		!background_debug_mode_en
		|-> !frozen)
		else $error("Debug mode entered while disarmed");

	AST_ENTER_OP: assert property (@(posedge sys_clk) disable iff (!nrst)
		enter_op && !bp_ack && !double_fault && background_debug_mode_en
		|=> frozen && entry_source == bgdbg_pkg::SRC_OPCODE)
		else $error("Armed enter opcode did not enter debug");

	AST_DF_SOURCE: assert property (@(posedge sys_clk) disable iff (!nrst)
		double_fault && background_debug_mode_en
		|=> entry_source == bgdbg_pkg::SRC_DOUBLE_FAULT)
		else $error("Double fault entry source wrong");

	AST_HALT_STAYS: assert property (@(posedge sys_clk) disable iff (!nrst)
		halted
		|=> halted && !exception.take)
		else $error("Halted state left or event taken");

	AST_SUBST: assert property (@(posedge sys_clk) disable iff (!nrst)
		running && instr.valid && is_breakpoint_request_n_op(instr.opcode) && breakpoint_request_n_substitute
		&& !bp_ack && !bus_fault
		|=> breakpoint_request_n_substitute_go && !exception.take)
		else $error("Breakpoint opcode substitution missing");

	AST_BREAKPOINT_REQUEST_N_ILLEGAL: assert property (@(posedge sys_clk) disable iff (!nrst)
		running && instr.valid && is_breakpoint_request_n_op(instr.opcode) && !breakpoint_request_n_substitute
		&& !bp_ack && !bus_fault
		|=> exception.take && exception.vector == `BGDBG_VEC_ILLEGAL)
		else $error("Breakpoint opcode did not trap");

	AST_TRACE_FLOW: assert property (@(posedge sys_clk) disable iff (!nrst)
		running && instr.valid && trace_enable && trace_flow_only && !instr.change_of_flow
		&& !bp_ack && !bus_fault && instr.opcode[15:12] != `BGDBG_LINE_A
		&& instr.opcode[15:12] != `BGDBG_LINE_F && !is_breakpoint_request_n_op(instr.opcode)
		&& instr.opcode != `BGDBG_OP_ENTER_DEBUG
		|=> !exception.take)
		else $error("Trace raised on straight-line instruction");

	AST_LINE_A: assert property (@(posedge sys_clk) disable iff (!nrst)
		running && instr.valid && instr.opcode[15:12] == `BGDBG_LINE_A && !bp_ack && !bus_fault
		|=> exception.take && exception.vector == `BGDBG_VEC_LINE_A)
		else $error("A-line opcode vector wrong");

	AST_LINE_F: assert property (@(posedge sys_clk) disable iff (!nrst)
		running && instr.valid && instr.opcode[15:12] == `BGDBG_LINE_F && !bp_ack && !bus_fault
		|=> exception.take && exception.vector == `BGDBG_VEC_LINE_F)
		else $error("F-line opcode vector wrong");

	AST_SUSPEND: assert property (@(posedge sys_clk) disable iff (!nrst)
		frozen || halted
		|-> exec_suspend && (frozen != halted))
		else $error("Execution not suspended");

	AST_FREEZE_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
		frozen && !debug_resume
		|=> frozen)
		else $error("Debug state left without resume");

	AST_RESUME: assert property (@(posedge sys_clk) disable iff (!nrst)
		frozen && debug_resume
		|=> !frozen)
		else $error("Resume did not leave debug state");

endmodule : bgdbg_entry

// ---- bench/bgdbg_tool.sv ----
/*
 Breakpoint source model: drives the shared active-low request line.
 Assumes the line is pulled up, so it reads high whenever no request is wanted.
*/
`timescale 1ns/1ps

module bgdbg_tool (
	// Clock
	sys_clk,
	// Request wish of the bench
	want_break,
	// Request line
	breakpoint_request_n
);
	input  wire logic sys_clk;
	input  wire logic want_break;
	output logic      breakpoint_request_n;

	initial breakpoint_request_n = 1'b1;

	// Changes just after an edge, like read data; held long before release
	always @(posedge sys_clk) breakpoint_request_n <= ~want_break;
endmodule : bgdbg_tool

// ---- bench/background_debug_entry_logic_test.sv ----
/*
 Self-checking bench of the debug-entry control.
 Assumes the design package and parameter header are compiled first.
*/
`timescale 1ns/1ps
`include "bgdbg_params.svh"

module background_debug_entry_logic_test;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic want_break = 1'b0;
	logic req_n;
	logic periph_n = 1'b1;
	logic [5:0] f = '0;
	logic [15:0] op = '0;
	logic subst = 1'b0;
	logic tr_en = 1'b0;
	logic tr_flow = 1'b0;
	logic armed, frozen, susp, halted, ack, sub_go;
	bgdbg_pkg::bgdbg_src_t src;
	bgdbg_pkg::bgdbg_exc_t exc;
	logic take, sawack, sawsub;
	logic [7:0] vec;
	int num_errors = 0;
	int check_count = 0;

	always #10 sys_clk = ~sys_clk;

	bgdbg_tool tool (.sys_clk(sys_clk), .want_break(want_break), .breakpoint_request_n(req_n));

	bgdbg_entry uut (.sys_clk(sys_clk), .nrst(nrst), .breakpoint_request_n(req_n),
		.periph_breakpoint_n(periph_n), .bus_cycle_end(f[4]), .bus_fault(f[3]),
		.bus_cycle_ok(f[2]), .instr({f[1], op, f[0]}), .breakpoint_request_n_substitute(subst),
		.debug_resume(f[5]), .trace_enable(tr_en), .trace_flow_only(tr_flow),
		.background_debug_mode_en(armed), .frozen(frozen), .exec_suspend(susp),
		.halted(halted), .entry_source(src), .exception(exc), .breakpoint_request_n_ack_cycle(ack),
		.breakpoint_request_n_substitute_go(sub_go));

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// One-cycle event {resume, cycle end, fault, ok, valid, flow}, then watch three cycles
	task automatic ev(input logic [5:0] fl, input logic [15:0] opc);
		take = 1'b0;
		sawack = 1'b0;
		sawsub = 1'b0;
		vec = '0;
		@(posedge sys_clk);
		f <= fl;
		op <= opc;
		@(posedge sys_clk);
		f <= '0;
		repeat (3) begin
			@(negedge sys_clk);
			if (exc.take === 1'b1) begin
				take = 1'b1;
				vec = exc.vector;
			end
			sawack |= (ack === 1'b1);
			sawsub |= (sub_go === 1'b1);
		end
	endtask : ev

	task automatic outcome(input logic t, input logic [7:0] v, input logic a, input logic fz);
		chk("exception", 16'(take), 16'(t));
		chk("vector", 16'(vec), 16'(t ? v : 8'h00));
		chk("ack cycle", 16'(sawack), 16'(a));
		chk("frozen", 16'(frozen), 16'(fz));
	endtask : outcome

	task automatic do_reset(input logic req);
		@(posedge sys_clk);
		want_break <= req;
		nrst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		want_break <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("armed", 16'(armed), 16'(req));
	endtask : do_reset

	task automatic brk(input logic periph);
		@(posedge sys_clk);
		want_break <= ~periph;
		periph_n <= ~periph;
		repeat (4) @(posedge sys_clk);
		ev(6'h10, '0);
		@(posedge sys_clk);
		want_break <= 1'b0;
		periph_n <= 1'b1;
	endtask : brk

	task automatic entered(input bgdbg_pkg::bgdbg_src_t s);
		outcome(1'b0, 8'h00, 1'b0, 1'b1);
		chk("source", 16'(src), 16'(s));
		chk("suspend", 16'(susp), 16'h1);
		ev(6'h20, '0);
		chk("resumed", 16'(frozen), 16'h0);
	endtask : entered

	task automatic sc_armed_sources;
		brk(1'b0);
		entered(bgdbg_pkg::SRC_BREAKPOINT);
		brk(1'b1);
		entered(bgdbg_pkg::SRC_BREAKPOINT);
		ev(6'h02, `BGDBG_OP_ENTER_DEBUG);
		entered(bgdbg_pkg::SRC_OPCODE);
		ev(6'h08, '0);
		ev(6'h08, '0);
		entered(bgdbg_pkg::SRC_DOUBLE_FAULT);
	endtask : sc_armed_sources

	task automatic sc_breakpoint_request_n_opcodes;
		for (int i = 0; i < 4; i++) begin
			subst <= i[1];
			ev(6'h02, i[0] ? `BGDBG_OP_BREAKPOINT_REQUEST_N_LAST : `BGDBG_OP_BREAKPOINT_REQUEST_N_FIRST);
			outcome(~i[1], `BGDBG_VEC_ILLEGAL, 1'b0, 1'b0);
			chk("substitute", 16'(sawsub), 16'(i[1]));
		end
		subst <= 1'b0;
	endtask : sc_breakpoint_request_n_opcodes

	task automatic sc_disarmed;
		brk(1'b0);
		outcome(1'b1, `BGDBG_VEC_BREAKPOINT, 1'b1, 1'b0);
		brk(1'b1);
		outcome(1'b1, `BGDBG_VEC_BREAKPOINT, 1'b1, 1'b0);
		ev(6'h02, `BGDBG_OP_ENTER_DEBUG);
		outcome(1'b1, `BGDBG_VEC_ILLEGAL, 1'b0, 1'b0);
		ev(6'h02, 16'ha123);
		outcome(1'b1, `BGDBG_VEC_LINE_A, 1'b0, 1'b0);
		ev(6'h02, 16'hf123);
		outcome(1'b1, `BGDBG_VEC_LINE_F, 1'b0, 1'b0);
	endtask : sc_disarmed

	task automatic sc_trace_halt;
		tr_en <= 1'b1;
		ev(6'h02, 16'h4e71);
		outcome(1'b1, `BGDBG_VEC_TRACE, 1'b0, 1'b0);
		tr_flow <= 1'b1;
		ev(6'h02, 16'h4e71);
		outcome(1'b0, 8'h00, 1'b0, 1'b0);
		ev(6'h03, 16'h4e75);
		outcome(1'b1, `BGDBG_VEC_TRACE, 1'b0, 1'b0);
		tr_en <= 1'b0;
		ev(6'h08, '0);
		ev(6'h08, '0);
		chk("halted", 16'(halted), 16'h1);
		ev(6'h02, `BGDBG_OP_ENTER_DEBUG);
		outcome(1'b0, 8'h00, 1'b0, 1'b0);
	endtask : sc_trace_halt

	task automatic report_and_stop;
		$display("Comparisons %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		#200000;
		num_errors++;
		report_and_stop();
	end

	initial begin
		do_reset(1'b1);
		sc_armed_sources();
		sc_breakpoint_request_n_opcodes();
		do_reset(1'b0);
		sc_disarmed();
		sc_trace_halt();
		do_reset(1'b1);
		report_and_stop();
	end
endmodule : background_debug_entry_logic_test
